// ==== core/obl_top.sv ====
// Purpose: option byte loader with key unlock, erase-program update and load check
// Assumes: apb slave on CORE_CLK, storage modelled on chip
// Notes:   launch request issues a system reset pulse and reruns the load
//
// Functional notes
// - boot zero from pin when select bit 0, else stored option bit
// - boot one with boot zero picks main memory, sram or system memory
// - parity bit 0 enables sram parity check, 1 disables it
// - window watchdog hardware-started at 0, software-started at 1
// - standby bit 0 freezes independent watchdog in standby
// - stop bit 0 freezes independent watchdog in stop
// - independent watchdog hardware-started at 0, software-started at 1
// - standby reset bit 0 resets on standby entry
// - stop reset bit 0 resets on stop entry
// - protect byte 0xAA is level 0, 0xCC level 2, else level 1
// - area word: last page in 21:16, first page in 5:0
// - options stay locked until main unlock then both option keys
// - wrong option key locks options until system reset and errors the bus
// - setting main lock also sets option guard; guard settable directly
// - start erases option page then programs all words
// - start writes inverted value into complement half
// - programmed values not applied; reads return the written register values
// - load after power reset or launch, launch makes a system reset
// - load reads each double word, copies it when complement matches
// - load ignores error-correction results
// - mismatch sets verify error and forces defaults
// - system reset copies loaded values into readable writable registers
// - stored word: value in low half, inverse in high half
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module obl_top
#(
  parameter int ERASE_CYC = obl_pkg::OBL_ERASE_CYC,
  parameter int PROG_CYC  = obl_pkg::OBL_PROG_CYC
)
(
  // clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET_N,
  // apb slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [11:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  output      logic [31:0]           PRDATA,
  output      logic                  PREADY,
  output      logic                  PSLVERR,
  // pins and system
  input  wire logic                  BOOT_PIN,
  output      logic                  SYS_RESET_N,
  output      logic                  HARD_FAULT,
  // applied configuration
  output      obl_pkg::obl_boot_type BOOT_TARGET,
  output      logic                  SRAM_PARITY_EN,
  output      logic                  WWDG_HW_START,
  output      logic                  IWDG_HW_START,
  output      logic                  IWDG_STANDBY_FREEZE,
  output      logic                  INDEP_WATCHDOG_STOP_RUN_FREEZE,
  output      logic                  STANDBY_RESET_EN,
  output      logic                  STOP_RESET_EN,
  output      obl_pkg::obl_level_type PROTECT_LEVEL,
  output      logic [5:0]            AREA_A_FIRST,
  output      logic [5:0]            AREA_A_LAST,
  output      logic [5:0]            AREA_B_FIRST,
  output      logic [5:0]            AREA_B_LAST
);
  import obl_pkg::*;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] ERASE_N = CNT_W'(ERASE_CYC);
  localparam logic [CNT_W-1:0] PROG_N  = CNT_W'(PROG_CYC);
  localparam logic [CNT_W-1:0] RST_N   = CNT_W'(OBL_RESET_CYC);
  localparam logic [1:0]       LAST_W  = 2'(OBL_WORDS - 1);

  // --------
  // state
  // --------
  typedef struct packed
  {
    obl_state_type    st;
    logic [1:0]       idx;
    logic [CNT_W-1:0] cnt;
    logic             lock;
    logic             guard;
    logic             key_stage;
    logic             main_stage;
    logic             key_dead;
    logic             busy;
    logic             verr;
    logic [31:0]      user;
    logic [31:0]      area_a;
    logic [31:0]      area_b;
    logic [31:0]      ld_user;
    logic [31:0]      ld_area_a;
    logic [31:0]      ld_area_b;
    logic [31:0]      rdata;
    logic             ready;
    logic             slverr;
    logic             fault;
    logic             sys_rst_n;
    logic             boot_s1;
    logic             boot_s2;
  } obl_regs_type;

  obl_regs_type r, n;
  logic [63:0]  st_rd;
  logic         st_erase;
  logic         st_wr;
  logic [63:0]  st_wdata;

  // --------
  // helpers
  // --------
  function automatic obl_level_type level_of(input logic [7:0] v);
    if (v == OBL_RDP_L0)
      return OBL_LVL0;
    else if (v == OBL_RDP_L2)
      return OBL_LVL2;
    return OBL_LVL1;
  endfunction

  function automatic logic [31:0] word_for(input logic [1:0] i, input obl_regs_type s);
    if (i == 2'd0)
      return s.user;
    else if (i == 2'd1)
      return s.area_a;
    return s.area_b;
  endfunction

  function automatic logic [31:0] dflt_for(input logic [1:0] i);
    return (i == 2'd0) ? OBL_USER_DFLT : OBL_AREA_DFLT;
  endfunction

  obl_store #(.ADDR_W(2)) u_store
  (
    .clk     (CORE_CLK),
    .erase   (st_erase),
    .wr_en   (st_wr),
    .addr    (r.idx),
    .wr_data (st_wdata),
    .rd_data (st_rd)
  );

  // --------
  // next state
  // --------
  always_comb
  begin
    logic        acc;
    logic [31:0] w;
    logic [31:0] wv;
    n        = r;
    wv       = 32'h00000000;
    acc      = PSEL && PENABLE && !r.ready;
    w        = word_for(r.idx, r);
    st_erase = 1'b0;
    st_wr    = 1'b0;
    st_wdata = {~w, w};
    n.ready  = 1'b0;
    n.slverr = 1'b0;
    n.fault  = 1'b0;
    n.boot_s1 = BOOT_PIN;
    n.boot_s2 = r.boot_s1;
    n.sys_rst_n = 1'b1;
    case (r.st)
      OBL_ST_LOAD_RD:
      begin
        n.st = OBL_ST_LOAD_WT;
      end
      OBL_ST_LOAD_WT:
      begin
        // raw halves compared, no error correction; unknown content counts as mismatch
        if (st_rd[31:0] == ~st_rd[63:32])
          wv = st_rd[31:0];
        else
        begin
          wv     = dflt_for(r.idx);
          n.verr = 1'b1;
        end
        if (r.idx == 2'd0)
          n.ld_user = wv & OBL_USER_MASK;
        else if (r.idx == 2'd1)
          n.ld_area_a = wv & OBL_AREA_MASK;
        else
          n.ld_area_b = wv & OBL_AREA_MASK;
        if (r.idx == LAST_W)
        begin
          n.idx = 2'd0;
          n.st  = OBL_ST_IDLE;
        end
        else
        begin
          n.idx = r.idx + 2'd1;
          n.st  = OBL_ST_LOAD_RD;
        end
      end
      OBL_ST_IDLE:
      begin
        // copy happens once per load, in the same cycle as its last word
        if (r.busy)
          n.busy = 1'b0;
      end
      OBL_ST_ERASE:
      begin
        st_erase = (r.cnt == '0);
        n.cnt    = r.cnt + 1'b1;
        if (r.cnt == ERASE_N)
        begin
          n.cnt = '0;
          n.idx = 2'd0;
          n.st  = OBL_ST_PROG;
        end
      end
      OBL_ST_PROG:
      begin
        st_wr = (r.cnt == '0);
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == PROG_N)
        begin
          n.cnt = '0;
          if (r.idx == LAST_W)
          begin
            n.idx  = 2'd0;
            n.busy = 1'b0;
            n.st   = OBL_ST_IDLE;
          end
          else
            n.idx = r.idx + 2'd1;
        end
      end
      OBL_ST_RESET:
      begin
        n.sys_rst_n = 1'b0;
        n.cnt       = r.cnt + 1'b1;
        if (r.cnt == RST_N)
        begin
          n.cnt   = '0;
          n.idx   = 2'd0;
          n.lock  = 1'b1;
          n.guard = 1'b1;
          n.key_stage  = 1'b0;
          n.main_stage = 1'b0;
          n.key_dead   = 1'b0;
          n.st    = OBL_ST_LOAD_RD;
        end
      end
      default:
      begin
        n.st = OBL_ST_IDLE;
      end
    endcase
    if (r.st == OBL_ST_LOAD_WT && r.idx == LAST_W)
    begin
      n.user   = n.ld_user;
      n.area_a = n.ld_area_a;
      n.area_b = n.ld_area_b;
    end
    // --------
    // apb access
    // --------
    if (acc)
    begin
      n.ready = 1'b1;
      n.rdata = 32'h00000000;
      if (PADDR == OBL_ADDR_CTRL)
      begin
        if (PWRITE)
        begin
          if (PWDATA[OBL_CTRL_LOCK])
          begin
            n.lock  = 1'b1;
            n.guard = 1'b1;
          end
          if (PWDATA[OBL_CTRL_GUARD])
            n.guard = 1'b1;
          if (!r.lock && !r.guard && PWDATA[OBL_CTRL_START] && !r.busy && r.st == OBL_ST_IDLE)
          begin
            n.busy = 1'b1;
            n.cnt  = '0;
            n.st   = OBL_ST_ERASE;
          end
          if (!r.lock && !r.guard && PWDATA[OBL_CTRL_LAUNCH] && !r.busy)
          begin
            n.cnt = '0;
            n.st  = OBL_ST_RESET;
          end
        end
        n.rdata[OBL_CTRL_LOCK]  = r.lock;
        n.rdata[OBL_CTRL_GUARD] = r.guard;
      end
      else if (PADDR == OBL_ADDR_MKEY)
      begin
        if (PWRITE && r.lock)
        begin
          if (!r.main_stage && PWDATA == OBL_MAIN_KEY1)
            n.main_stage = 1'b1;
          else if (r.main_stage && PWDATA == OBL_MAIN_KEY2)
          begin
            n.lock       = 1'b0;
            n.main_stage = 1'b0;
          end
          else
          begin
            n.main_stage = 1'b0;
            n.slverr     = 1'b1;
          end
        end
      end
      else if (PADDR == OBL_ADDR_KEY)
      begin
        if (PWRITE)
        begin
          if (!r.key_dead && !r.lock && r.guard && !r.key_stage && PWDATA == OBL_OPT_KEY1)
            n.key_stage = 1'b1;
          else if (!r.key_dead && !r.lock && r.guard && r.key_stage && PWDATA == OBL_OPT_KEY2)
          begin
            n.guard     = 1'b0;
            n.key_stage = 1'b0;
          end
          else
          begin
            n.key_dead = 1'b1;
            n.key_stage = 1'b0;
            n.slverr   = 1'b1;
            n.fault    = 1'b1;
          end
        end
      end
      else if (PADDR == OBL_ADDR_STAT)
      begin
        if (PWRITE && PWDATA[OBL_STAT_VERR] && r.st != OBL_ST_LOAD_WT)
          n.verr = 1'b0;
        n.rdata[OBL_STAT_BUSY]   = r.busy;
        n.rdata[OBL_STAT_VERR]   = r.verr;
        n.rdata[OBL_STAT_KEYERR] = r.key_dead;
      end
      else if (PADDR == OBL_ADDR_USER)
      begin
        if (PWRITE && !r.guard && !r.busy)
          n.user = PWDATA & OBL_USER_MASK;
        n.rdata = r.user;
      end
      else if (PADDR == OBL_ADDR_AREA_A)
      begin
        if (PWRITE && !r.guard && !r.busy)
          n.area_a = PWDATA & OBL_AREA_MASK;
        n.rdata = r.area_a;
      end
      else if (PADDR == OBL_ADDR_AREA_B)
      begin
        if (PWRITE && !r.guard && !r.busy)
          n.area_b = PWDATA & OBL_AREA_MASK;
        n.rdata = r.area_b;
      end
      else
        n.slverr = 1'b1;
    end
  end

  // --------
  // registers
  // --------
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      r            <= '0;
      r.st         <= OBL_ST_LOAD_RD;
      r.lock       <= 1'b1;
      r.guard      <= 1'b1;
      r.sys_rst_n  <= 1'b0;
      r.ld_user    <= OBL_USER_DFLT;
      r.ld_area_a  <= OBL_AREA_DFLT;
      r.ld_area_b  <= OBL_AREA_DFLT;
    end
    else
      r <= n;
  end

  // --------
  // applied configuration, from loaded copy and synchronised boot pin only
  // --------
  logic boot0_sel;
  always_comb
  begin
    boot0_sel = r.ld_user[OBL_BIT_BOOTSEL] ? r.ld_user[OBL_BIT_BOOT0] : r.boot_s2;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      SYS_RESET_N <= 1'b0;
      HARD_FAULT  <= 1'b0;
      BOOT_TARGET <= OBL_BOOT_MAIN;
      SRAM_PARITY_EN <= 1'b0;
      WWDG_HW_START  <= 1'b0;
      IWDG_HW_START  <= 1'b0;
      IWDG_STANDBY_FREEZE <= 1'b0;
      INDEP_WATCHDOG_STOP_RUN_FREEZE    <= 1'b0;
      STANDBY_RESET_EN    <= 1'b0;
      STOP_RESET_EN       <= 1'b0;
      PROTECT_LEVEL <= OBL_LVL1;
      AREA_A_FIRST  <= 6'h00;
      AREA_A_LAST   <= 6'h00;
      AREA_B_FIRST  <= 6'h00;
      AREA_B_LAST   <= 6'h00;
    end
    else
    begin
      PRDATA  <= n.rdata;
      PREADY  <= n.ready;
      PSLVERR <= n.slverr;
      SYS_RESET_N <= n.sys_rst_n;
      HARD_FAULT  <= n.fault;
      if (!boot0_sel)
        BOOT_TARGET <= OBL_BOOT_MAIN;
      else if (r.ld_user[OBL_BIT_BOOT1])
        BOOT_TARGET <= OBL_BOOT_SYS;
      else
        BOOT_TARGET <= OBL_BOOT_SRAM;
      SRAM_PARITY_EN <= !r.ld_user[OBL_BIT_PARITY];
      WWDG_HW_START  <= !r.ld_user[OBL_BIT_WWDG];
      IWDG_STANDBY_FREEZE <= !r.ld_user[OBL_BIT_IWSTBY];
      INDEP_WATCHDOG_STOP_RUN_FREEZE    <= !r.ld_user[OBL_BIT_IWSTOP];
      IWDG_HW_START  <= !r.ld_user[OBL_BIT_IWSW];
      STANDBY_RESET_EN <= !r.ld_user[OBL_BIT_RSTSTBY];
      STOP_RESET_EN    <= !r.ld_user[OBL_BIT_RSTSTOP];
      PROTECT_LEVEL <= level_of(r.ld_user[OBL_RDP_MSB:OBL_RDP_LSB]);
      AREA_A_FIRST  <= r.ld_area_a[OBL_FIRST_MSB:OBL_FIRST_LSB];
      AREA_A_LAST   <= r.ld_area_a[OBL_LAST_MSB:OBL_LAST_LSB];
      AREA_B_FIRST  <= r.ld_area_b[OBL_FIRST_MSB:OBL_FIRST_LSB];
      AREA_B_LAST   <= r.ld_area_b[OBL_LAST_MSB:OBL_LAST_LSB];
    end
  end

endmodule // obl_top

// ==== common/obl_pkg.sv ====
// Purpose: shared constants and types for the option byte loader
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   option storage holds 64-bit words, value low and inverse high
package obl_pkg;

  // --------
  // register map (byte offsets on apb)
  // --------
  localparam logic [11:0] OBL_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] OBL_ADDR_KEY    = 12'h004;
  localparam logic [11:0] OBL_ADDR_STAT   = 12'h008;
  localparam logic [11:0] OBL_ADDR_USER   = 12'h00C;
  localparam logic [11:0] OBL_ADDR_AREA_A = 12'h010;
  localparam logic [11:0] OBL_ADDR_AREA_B = 12'h014;
  localparam logic [11:0] OBL_ADDR_MKEY   = 12'h018;

  // --------
  // storage addresses of the option words
  // --------
  localparam logic [31:0] OBL_STORE_USER   = 32'h1FFF7800;
  localparam logic [31:0] OBL_STORE_AREA_A = 32'h1FFF7818;
  localparam logic [31:0] OBL_STORE_AREA_B = 32'h1FFF7820;
  localparam int          OBL_WORDS        = 3;

  // --------
  // control register fields
  // --------
  localparam int OBL_CTRL_START  = 17;
  localparam int OBL_CTRL_LAUNCH = 27;
  localparam int OBL_CTRL_GUARD  = 30;
  localparam int OBL_CTRL_LOCK   = 31;

  // status fields
  localparam int OBL_STAT_BUSY   = 16;
  localparam int OBL_STAT_VERR   = 15;
  localparam int OBL_STAT_KEYERR = 14;

  // --------
  // user option fields
  // --------
  localparam int OBL_BIT_BOOT0   = 26;
  localparam int OBL_BIT_BOOT1   = 25;
  localparam int OBL_BIT_BOOTSEL = 24;
  localparam int OBL_BIT_PARITY  = 22;
  localparam int OBL_BIT_WWDG    = 19;
  localparam int OBL_BIT_IWSTBY  = 18;
  localparam int OBL_BIT_IWSTOP  = 17;
  localparam int OBL_BIT_IWSW    = 16;
  localparam int OBL_BIT_RSTSTBY = 14;
  localparam int OBL_BIT_RSTSTOP = 13;
  localparam int OBL_RDP_MSB     = 7;
  localparam int OBL_RDP_LSB     = 0;
  localparam int OBL_LAST_MSB    = 21;
  localparam int OBL_LAST_LSB    = 16;
  localparam int OBL_FIRST_MSB   = 5;
  localparam int OBL_FIRST_LSB   = 0;

  localparam logic [31:0] OBL_USER_MASK = 32'h07CF60FF;
  localparam logic [31:0] OBL_AREA_MASK = 32'h003F003F;
  // mismatch defaults: all user bits 1 with level 1, area first above last
  localparam logic [31:0] OBL_USER_DFLT = 32'h07CF60FF;
  localparam logic [31:0] OBL_AREA_DFLT = 32'h0000003F;

  localparam logic [7:0] OBL_RDP_L0 = 8'hAA;
  localparam logic [7:0] OBL_RDP_L2 = 8'hCC;

  // --------
  // keys
  // --------
  localparam logic [31:0] OBL_OPT_KEY1  = 32'h08192A3B;
  localparam logic [31:0] OBL_OPT_KEY2  = 32'h4C5D6E7F;
  localparam logic [31:0] OBL_MAIN_KEY1 = 32'h45670123;
  localparam logic [31:0] OBL_MAIN_KEY2 = 32'hCDEF89AB;

  // --------
  // timing
  // --------
  localparam int OBL_CLK_MHZ       = 40;
  localparam int OBL_ERASE_US      = 22;
  localparam int OBL_PROG_US       = 85;
  localparam int OBL_ERASE_CYC     = OBL_ERASE_US * OBL_CLK_MHZ;
  localparam int OBL_PROG_CYC      = OBL_PROG_US * OBL_CLK_MHZ;
  localparam int OBL_RESET_CYC     = 8;

  // boot targets
  typedef enum logic [1:0]
  {
    OBL_BOOT_MAIN = 2'b00,
    OBL_BOOT_SYS  = 2'b01,
    OBL_BOOT_SRAM = 2'b10
  } obl_boot_type;

  // read protect levels
  typedef enum logic [1:0]
  {
    OBL_LVL0 = 2'b00,
    OBL_LVL1 = 2'b01,
    OBL_LVL2 = 2'b10
  } obl_level_type;

  typedef enum logic [2:0]
  {
    OBL_ST_LOAD_RD = 3'b000,
    OBL_ST_LOAD_WT = 3'b001,
    OBL_ST_IDLE    = 3'b010,
    OBL_ST_ERASE   = 3'b011,
    OBL_ST_PROG    = 3'b100,
    OBL_ST_RESET   = 3'b101
  } obl_state_type;

endpackage

// ==== core/obl_store.sv ====
// Purpose: option storage page, four 64-bit words
// Assumes: registered read data, erase sets all bits
// Notes:   contents survive system reset, only erase and write change them
`timescale 1ns/100ps
module obl_store
#(
  parameter int ADDR_W = 2
)
(
  // clock
  input  wire logic              clk,
  // access
  input  wire logic              erase,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [63:0]       wr_data,
  output      logic [63:0]       rd_data
);

  logic [63:0] mem [0:(1<<ADDR_W)-1];

  // --------
  // storage array
  // --------
  // no reset: nonvolatile content must outlive every reset
  always_ff @(posedge clk)
  begin
    if (erase)
    begin
      for (int i = 0; i < (1<<ADDR_W); i++)
        mem[i] <= {64{1'b1}};
    end
    else if (wr_en)
      mem[addr] <= wr_data;
    rd_data <= mem[addr];
  end

endmodule // obl_store

// ==== testbench/obl_top_properties.sv ====
// Purpose: port-level properties of the option byte loader
// Assumes: one clock domain, asynchronous active-low power reset
// Notes:   configuration outputs other than boot target may only move shortly after a system reset
`timescale 1ns/100ps
module obl_top_properties
  import obl_pkg::*;
#(
  parameter int ERASE_CYC = 4,
  parameter int PROG_CYC  = 4
)
(
  // clock and reset
  input wire logic                   CORE_CLK,
  input wire logic                   RESET_N,
  // apb
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [11:0]            PADDR,
  input wire logic [31:0]            PWDATA,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  // system
  input wire logic                   SYS_RESET_N,
  input wire logic                   HARD_FAULT,
  input wire obl_pkg::obl_boot_type  BOOT_TARGET,
  input wire logic                   SRAM_PARITY_EN,
  input wire logic                   WWDG_HW_START,
  input wire logic                   IWDG_HW_START,
  input wire logic                   IWDG_STANDBY_FREEZE,
  input wire logic                   INDEP_WATCHDOG_STOP_RUN_FREEZE,
  input wire logic                   STANDBY_RESET_EN,
  input wire logic                   STOP_RESET_EN,
  input wire obl_pkg::obl_level_type PROTECT_LEVEL,
  input wire logic [5:0]             AREA_A_FIRST,
  input wire logic [5:0]             AREA_A_LAST,
  input wire logic [5:0]             AREA_B_FIRST,
  input wire logic [5:0]             AREA_B_LAST
);
  logic [4:0]  since_r;
  logic [32:0] cfg;
  logic        done;
  assign cfg = {SRAM_PARITY_EN, WWDG_HW_START, IWDG_HW_START, IWDG_STANDBY_FREEZE, INDEP_WATCHDOG_STOP_RUN_FREEZE,
                STANDBY_RESET_EN, STOP_RESET_EN, PROTECT_LEVEL, AREA_A_FIRST, AREA_A_LAST, AREA_B_FIRST, AREA_B_LAST};
  assign done = PSEL && PENABLE && PREADY;
  // saturating count of cycles since the last system reset
  always_ff @(posedge CORE_CLK or negedge RESET_N)
    if (!RESET_N)
      since_r <= 5'h00;
    else if (!SYS_RESET_N)
      since_r <= 5'h00;
    else if (since_r != 5'h1F)
      since_r <= since_r + 5'h01;
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  a_ready_wait: assert property ($rose(PENABLE) && PSEL |=> PREADY) else $error("ready not after one wait");
  a_unmapped_err: assert property (done && PADDR > 12'h018 |-> PSLVERR) else $error("unmapped access accepted");
  a_level_legal: assert property (PROTECT_LEVEL != 2'b11) else $error("illegal protect level");
  a_target_legal: assert property (BOOT_TARGET != 2'b11) else $error("illegal boot target");
  a_cfg_hold: assert property ($changed(cfg) |-> since_r < 5'h14) else $error("config moved without reload");
  a_launch_reset: assert property (done && PWRITE && PADDR == OBL_ADDR_CTRL && PWDATA[OBL_CTRL_LAUNCH]
    |-> ##[0:3] !SYS_RESET_N) else $error("launch gave no system reset");
  a_reset_long: assert property ($fell(SYS_RESET_N) |-> !SYS_RESET_N [*8]) else $error("system reset too short");
  a_fault_cause: assert property (HARD_FAULT |-> PSLVERR || $past(PSLVERR) || $past(PSLVERR, 2))
    else $error("fault without bus error");
  a_fault_pulse: assert property (HARD_FAULT |=> !HARD_FAULT) else $error("fault longer than one cycle");
  cover property (HARD_FAULT);
  cover property ($fell(SYS_RESET_N));
  cover property (done && PSLVERR);
endmodule // obl_top_properties

bind obl_top obl_top_properties #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) u_props (.*);

// ==== testbench/obl_sw_model.sv ====
// Purpose: software side, an apb master issuing one transfer at a time
// Assumes: called right after a rising edge
// Notes:   released address and data show inverted values
`timescale 1ns/100ps
module obl_sw_model
(
  // clock and answer
  input  wire logic        clk,
  input  wire logic        pready,
  // request
  output      logic        psel,
  output      logic        penable,
  output      logic        pwrite,
  output      logic [11:0] paddr,
  output      logic [31:0] pwdata
);
  initial
    {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 64)
      begin
        n++;
        @(posedge clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clk);
    end
  endtask
endmodule // obl_sw_model

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the option byte loader
// Assumes: short erase and program counts, storage blank at power-up
// Notes:   expected bus answers queue up for the monitor process
`timescale 1ns/100ps
module testbench;
  import obl_pkg::*;
  typedef struct { logic [31:0] d; logic [31:0] m; logic e; } obl_note_type;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic boot_pin = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, sys_reset_n, hard_fault;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [34:0] outs;
  obl_note_type notes[$];
  obl_note_type nt;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int faults = 0;
  int seed = 32'h69642c02;
  logic [31:0] u, a, b;
  logic [34:0] ev;
  always #12.5 core_clk = ~core_clk;
  obl_sw_model u_sw (.clk(core_clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  obl_top #(.ERASE_CYC(4), .PROG_CYC(4)) u_dut
  (
    .CORE_CLK(core_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BOOT_PIN(boot_pin),
    .SYS_RESET_N(sys_reset_n), .HARD_FAULT(hard_fault), .BOOT_TARGET(outs[34:33]), .SRAM_PARITY_EN(outs[32]),
    .WWDG_HW_START(outs[31]), .IWDG_HW_START(outs[30]), .IWDG_STANDBY_FREEZE(outs[29]),
    .INDEP_WATCHDOG_STOP_RUN_FREEZE(outs[28]), .STANDBY_RESET_EN(outs[27]), .STOP_RESET_EN(outs[26]),
    .PROTECT_LEVEL(outs[25:24]), .AREA_A_FIRST(outs[23:18]), .AREA_A_LAST(outs[17:12]),
    .AREA_B_FIRST(outs[11:6]), .AREA_B_LAST(outs[5:0])
  );
  function automatic logic [34:0] expv(input logic [31:0] uw, aw, bw, input logic pin);
    logic [1:0] bt, lv;
    begin
      bt = !pin ? OBL_BOOT_MAIN : (uw[25] ? OBL_BOOT_SYS : OBL_BOOT_SRAM);
      lv = (uw[7:0] == 8'hAA) ? OBL_LVL0 : (uw[7:0] == 8'hCC) ? OBL_LVL2 : OBL_LVL1;
      expv = {bt, ~uw[22], ~uw[19], ~uw[16], ~uw[18], ~uw[17], ~uw[14], ~uw[13], lv, aw[5:0], aw[21:16],
              bw[5:0], bw[21:16]};
    end
  endfunction
  task automatic chk(input logic [34:0] got, exp, input string s);
    begin
      checked++;
      if (got !== exp)
      begin
        miscompares++;
        $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
      end
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d, m, input logic e);
    begin
      notes.push_back('{d & m, m, e});
      u_sw.xfer(w, ad, d);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] d, m);
    bus(1'b0, ad, d, m, 1'b0);
  endtask
  task automatic unlock(input logic [31:0] k1);
    begin
      wr(OBL_ADDR_MKEY, OBL_MAIN_KEY1);
      wr(OBL_ADDR_MKEY, OBL_MAIN_KEY2);
      bus(1'b1, OBL_ADDR_KEY, k1, 32'h0, k1 !== OBL_OPT_KEY1);
      if (k1 === OBL_OPT_KEY1)
        wr(OBL_ADDR_KEY, OBL_OPT_KEY2);
    end
  endtask
  // poll and system-reset waits are bounded; the monitor ignores answers when no note is queued
  task automatic wait_on(input logic stat);
    int n;
    begin
      n = 0;
      if (stat)
        rd(OBL_ADDR_STAT, 32'h0, 32'h0);
      while ((stat ? prdata[OBL_STAT_BUSY] : !sys_reset_n) !== 1'b0 && n < 100)
      begin
        n++;
        if (stat)
          rd(OBL_ADDR_STAT, 32'h0, 32'h0);
        else
          @(posedge core_clk);
      end
      chk(35'(n == 100), 35'h0, "wait ran out");
    end
  endtask
  task automatic results;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      chk({2'b00, pslverr, prdata & nt.m}, {2'b00, nt.e, nt.d}, "bus answer");
    end
  always @(posedge core_clk)
  begin
    cycles++;
    faults += (hard_fault === 1'b1);
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    // --------
    // blank storage loads defaults
    // --------
    ev = {2'b00, 7'h00, OBL_LVL1, 6'h3F, 6'h00, 6'h3F, 6'h00};
    chk({2'b00, outs[32:0]}, ev, "default outputs");
    rd(OBL_ADDR_STAT, 32'h0000_8000, 32'h0000_8000);
    rd(OBL_ADDR_AREA_A, OBL_AREA_DFLT, 32'hFFFF_FFFF);
    wr(OBL_ADDR_USER, 32'h0);
    rd(OBL_ADDR_USER, OBL_USER_DFLT, 32'hFFFF_FFFF);
    bus(1'b0, 12'h01C, 32'h0, 32'h0, 1'b1);
    wr(OBL_ADDR_STAT, 32'h0000_8000);
    $display("defaults done");
    for (int it = 0; it < 3; it++)
    begin
      unlock(OBL_OPT_KEY1);
      u = $random(seed) & OBL_USER_MASK & 32'hFEFF_FF00;
      u[7:0] = (it == 0) ? 8'hAA : (it == 1) ? 8'h3C : 8'hCC;
      a = $random(seed) & OBL_AREA_MASK;
      b = $random(seed) & OBL_AREA_MASK;
      wr(OBL_ADDR_USER, u);
      wr(OBL_ADDR_AREA_A, a);
      wr(OBL_ADDR_AREA_B, b);
      rd(OBL_ADDR_USER, u, 32'hFFFF_FFFF);
      rd(OBL_ADDR_AREA_B, b, 32'hFFFF_FFFF);
      wait_on(1'b1);
      wr(OBL_ADDR_CTRL, 32'h0002_0000);
      rd(OBL_ADDR_STAT, 32'h0001_0000, 32'h0001_0000);
      wait_on(1'b1);
      chk({2'b00, outs[32:0]}, {2'b00, ev[32:0]}, "outputs held");
      rd(OBL_ADDR_USER, u, 32'hFFFF_FFFF);
      boot_pin <= (it != 1);
      wr(OBL_ADDR_CTRL, 32'h0800_0000);
      wait_on(1'b0);
      repeat (12) @(posedge core_clk);
      ev = expv(u, a, b, boot_pin);
      chk(outs, ev, "loaded outputs");
      rd(OBL_ADDR_STAT, 32'h0, 32'h0000_8000);
      rd(OBL_ADDR_AREA_A, a, 32'hFFFF_FFFF);
      $display("load pass %0d done", it);
    end
    // --------
    // relock and wrong key
    // --------
    unlock(OBL_OPT_KEY1);
    rd(OBL_ADDR_CTRL, 32'h0, 32'hC000_0000);
    wr(OBL_ADDR_CTRL, 32'h8000_0000);
    rd(OBL_ADDR_CTRL, 32'hC000_0000, 32'hC000_0000);
    unlock(32'h1234_5678);
    rd(OBL_ADDR_CTRL, 32'h4000_0000, 32'h4000_0000);
    wr(OBL_ADDR_USER, ~u);
    rd(OBL_ADDR_USER, u, 32'hFFFF_FFFF);
    chk(35'(faults), 35'h1, "fault count");
    $display("lock tests done");
    results();
  end
endmodule // testbench
